/* File: hdl/cmp_neg_bit_pkg.sv */
// Constants shared by the compare, negate and bit-operation execution unit.
// Assumes an 8-bit core that issues one operation at a time.
package cmp_neg_bit_pkg;

   // ----------------------------------------------------------------------
   // Widths and flag layout
   // ----------------------------------------------------------------------
   localparam int DATA_W = 8;
   localparam int MEM_AW = 8;
   localparam int IO_AW = 6;
   localparam int FLAG_Z = 0;
   localparam int FLAG_C = 1;
   localparam int FLAG_AC = 2;
   localparam int FLAG_OV = 3;

   // ----------------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------------
   localparam logic [7:0] FLAG_RST = 8'h00;
   localparam logic [7:0] DATA_RST = 8'h00;

   // ----------------------------------------------------------------------
   // Operation codes on the sequencer port
   // ----------------------------------------------------------------------
   localparam logic [3:0] OP_NEG_M = 4'h1;
   localparam logic [3:0] OP_COMP_AM = 4'h2;
   localparam logic [3:0] OP_COMP_MA = 4'h3;
   localparam logic [3:0] OP_CLR_IO = 4'h4;
   localparam logic [3:0] OP_SET_IO = 4'h5;
   localparam logic [3:0] OP_SWAPC_IO = 4'h6;
   localparam logic [3:0] OP_CLR_M = 4'h7;
   localparam logic [3:0] OP_SET_M = 4'h8;

   // ----------------------------------------------------------------------
   // Sequencer states
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_EXEC} state_t;

endpackage

/* File: hdl/cmp_neg_bit_unit.sv */
// Execution unit for memory negate, the two compares and bit operations.
// Assumes memory/IO read data that stand while the read strobe stands,
// and that the sequencer waits for done_o before issuing the next op.

module cmp_neg_bit_unit (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic start_i,
   input wire logic [3:0] op_i,
   input wire logic [7:0] mem_addr_i,
   input wire logic [5:0] io_addr_i,
   input wire logic [2:0] bit_sel_i,
   input wire logic [7:0] accumulator_i,
   input wire logic [7:0] flag_i,
   input wire logic [7:0] mem_rdata_i,
   input wire logic [7:0] io_rdata_i,
   input wire logic [7:0] port_dir_i,
   input wire logic [7:0] port_pin_i,
   output logic [7:0] mem_addr_o,
   output logic mem_rd_o,
   output logic mem_wr_o,
   output logic [7:0] mem_wdata_o,
   output logic [5:0] io_addr_o,
   output logic io_rd_o,
   output logic io_wr_o,
   output logic [7:0] io_wdata_o,
   output logic flag_wr_o,
   output logic [7:0] flag_wdata_o,
   output logic busy_o,
   output logic done_o
);

   // ----------------------------------------------------------------------
   // Latched request and state
   // ----------------------------------------------------------------------
   cmp_neg_bit_pkg::state_t state;
   logic [3:0] op;
   logic [2:0] bit_sel;
   logic [7:0] acc;
   logic [7:0] flags;
   logic [7:0] pin_meta;
   logic [7:0] pin_sync;
   logic is_io;

   // Pins come from outside the clock domain, so they pass two flops.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pin_meta <= cmp_neg_bit_pkg::DATA_RST;
         pin_sync <= cmp_neg_bit_pkg::DATA_RST;
      end else begin
         pin_meta <= port_pin_i;
         pin_sync <= pin_meta;
      end
   end

   assign is_io = (op == cmp_neg_bit_pkg::OP_CLR_IO) ||
                  (op == cmp_neg_bit_pkg::OP_SET_IO) ||
                  (op == cmp_neg_bit_pkg::OP_SWAPC_IO);

   // ----------------------------------------------------------------------
   // Arithmetic
   // ----------------------------------------------------------------------
   logic [7:0] minuend;
   logic [7:0] subtrahend;
   logic [8:0] diff;
   logic [4:0] low_diff;
   logic [7:0] neg_val;
   logic [7:0] bit_mask;
   logic sub_ov;

   // Compare direction picks which operand is subtracted.
   always_comb begin
      if (op == cmp_neg_bit_pkg::OP_COMP_MA) begin
         minuend = mem_rdata_i;
         subtrahend = acc;
      end else begin
         minuend = acc;
         subtrahend = mem_rdata_i;
      end
   end

   assign diff = {1'b0, minuend} - {1'b0, subtrahend};
   assign low_diff = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]};
   assign sub_ov = (minuend[7] ^ subtrahend[7]) & (minuend[7] ^ diff[7]);
   assign neg_val = 8'h00 - mem_rdata_i;
   assign bit_mask = 8'h01 << bit_sel;

   // ----------------------------------------------------------------------
   // Result selection
   // ----------------------------------------------------------------------
   logic next_mem_wr;
   logic next_io_wr;
   logic next_flag_wr;
   logic [7:0] next_mem_wdata;
   logic [7:0] next_io_wdata;
   logic [7:0] next_flags;
   logic old_c;
   logic io_bit;

   assign old_c = flags[cmp_neg_bit_pkg::FLAG_C];

   // Input pins report the synchronised pin level; output bits report latch.
   assign io_bit = port_dir_i[bit_sel] ? io_rdata_i[bit_sel]
                                       : pin_sync[bit_sel];

   // Forms the writes for the execute cycle; flags untouched unless noted.
   always_comb begin
      next_mem_wr = 1'b0;
      next_io_wr = 1'b0;
      next_flag_wr = 1'b0;
      next_mem_wdata = mem_rdata_i;
      next_io_wdata = io_rdata_i;
      next_flags = flags;
      unique case (op)
         cmp_neg_bit_pkg::OP_NEG_M: begin
            next_mem_wr = 1'b1;
            next_mem_wdata = neg_val;
            next_flag_wr = 1'b1;
            next_flags[cmp_neg_bit_pkg::FLAG_Z] = (neg_val == 8'h00);
         end
         cmp_neg_bit_pkg::OP_COMP_AM, cmp_neg_bit_pkg::OP_COMP_MA: begin
            next_flag_wr = 1'b1;
            next_flags[cmp_neg_bit_pkg::FLAG_Z] = (diff[7:0] == 8'h00);
            next_flags[cmp_neg_bit_pkg::FLAG_C] = diff[8];
            next_flags[cmp_neg_bit_pkg::FLAG_AC] = low_diff[4];
            next_flags[cmp_neg_bit_pkg::FLAG_OV] = sub_ov;
         end
         cmp_neg_bit_pkg::OP_CLR_IO: begin
            next_io_wr = 1'b1;
            next_io_wdata = io_rdata_i & ~bit_mask;
         end
         cmp_neg_bit_pkg::OP_SET_IO: begin
            next_io_wr = 1'b1;
            next_io_wdata = io_rdata_i | bit_mask;
         end
         cmp_neg_bit_pkg::OP_SWAPC_IO: begin
            next_io_wr = 1'b1;
            next_io_wdata = old_c ? (io_rdata_i | bit_mask)
                                  : (io_rdata_i & ~bit_mask);
            next_flag_wr = 1'b1;
            next_flags[cmp_neg_bit_pkg::FLAG_C] = io_bit;
         end
         cmp_neg_bit_pkg::OP_CLR_M: begin
            next_mem_wr = 1'b1;
            next_mem_wdata = mem_rdata_i & ~bit_mask;
         end
         cmp_neg_bit_pkg::OP_SET_M: begin
            next_mem_wr = 1'b1;
            next_mem_wdata = mem_rdata_i | bit_mask;
         end
         default: begin
         end
      endcase
   end

   // ----------------------------------------------------------------------
   // Sequencer: read operand, then write result
   // ----------------------------------------------------------------------
   // An operation is taken on an edge where the unit idles and start_i is
   // high. The read strobe stands in the next cycle, and the operand must
   // arrive while it stands, because the execute edge samples it directly.
   // Results, write strobes and done_o stand in the cycle after that, and
   // busy_o falls one cycle later still. A start that comes while the unit
   // is busy is dropped without any sign, so the sequencer must wait for
   // done_o and then give the unit one more edge to return to idle.
   logic take;
   logic start_is_io;
   logic exec_edge;

   // An operation is taken only from idle; a start while busy is ignored.
   assign take = (state == cmp_neg_bit_pkg::ST_IDLE) && start_i;

   // The results are formed on the edge that leaves the read state.
   assign exec_edge = (state == cmp_neg_bit_pkg::ST_READ);

   // IO operations fetch from the IO space, all others from data memory.
   assign start_is_io = (op_i == cmp_neg_bit_pkg::OP_CLR_IO) ||
                        (op_i == cmp_neg_bit_pkg::OP_SET_IO) ||
                        (op_i == cmp_neg_bit_pkg::OP_SWAPC_IO);

   // Steps idle, read, execute; one operation takes three cycles.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state <= cmp_neg_bit_pkg::ST_IDLE;
      end else begin
         unique case (state)
            cmp_neg_bit_pkg::ST_IDLE: begin
               if (take) begin
                  state <= cmp_neg_bit_pkg::ST_READ;
               end
            end
            cmp_neg_bit_pkg::ST_READ: begin
               state <= cmp_neg_bit_pkg::ST_EXEC;
            end
            cmp_neg_bit_pkg::ST_EXEC: begin
               state <= cmp_neg_bit_pkg::ST_IDLE;
            end
            default: begin
               state <= cmp_neg_bit_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Operands are captured on the taking edge and held through execute.
   // The flag byte is kept whole so that untouched flags pass through.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         op <= 4'h0;
         bit_sel <= 3'h0;
         acc <= cmp_neg_bit_pkg::DATA_RST;
         flags <= cmp_neg_bit_pkg::FLAG_RST;
      end else if (take) begin
         op <= op_i;
         bit_sel <= bit_sel_i;
         acc <= accumulator_i;
         flags <= flag_i;
      end
   end

   // Memory read strobe and address for negate, compares and memory bits.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mem_addr_o <= 8'h00;
         mem_rd_o <= 1'b0;
      end else begin
         mem_rd_o <= 1'b0;
         if (take) begin
            mem_addr_o <= mem_addr_i;
            mem_rd_o <= !start_is_io;
         end
      end
   end

   // IO read strobe and address for the three IO bit operations.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         io_addr_o <= 6'h00;
         io_rd_o <= 1'b0;
      end else begin
         io_rd_o <= 1'b0;
         if (take) begin
            io_addr_o <= io_addr_i;
            io_rd_o <= start_is_io;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Result registers
   // ----------------------------------------------------------------------
   // Each write strobe stands for the single cycle after the execute edge.
   // The data stay until the next operation, so a slow consumer still
   // sees them, but only the strobe says that they are new.

   // Memory write: negate and memory bit ops; compares never write.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mem_wr_o <= 1'b0;
         mem_wdata_o <= cmp_neg_bit_pkg::DATA_RST;
      end else begin
         if (exec_edge) begin
            mem_wr_o <= next_mem_wr && !is_io;
            mem_wdata_o <= next_mem_wdata;
         end else begin
            mem_wr_o <= 1'b0;
         end
      end
   end

   // IO write: clear, set and exchange of an IO bit.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         io_wr_o <= 1'b0;
         io_wdata_o <= cmp_neg_bit_pkg::DATA_RST;
      end else begin
         if (exec_edge) begin
            io_wr_o <= next_io_wr;
            io_wdata_o <= next_io_wdata;
         end else begin
            io_wr_o <= 1'b0;
         end
      end
   end

   // Flag write: negate, compares and the carry exchange only.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         flag_wr_o <= 1'b0;
         flag_wdata_o <= cmp_neg_bit_pkg::FLAG_RST;
      end else begin
         if (exec_edge) begin
            flag_wr_o <= next_flag_wr;
            flag_wdata_o <= next_flags;
         end else begin
            flag_wr_o <= 1'b0;
         end
      end
   end

   // Done pulses beside the write strobes, also for undecoded codes.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         done_o <= 1'b0;
      end else begin
         done_o <= exec_edge;
      end
   end

   // Busy from the cycle after start until the result is written.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         busy_o <= 1'b0;
      end else begin
         busy_o <= (state == cmp_neg_bit_pkg::ST_IDLE) ? start_i
                 : (state == cmp_neg_bit_pkg::ST_READ);
      end
   end

endmodule

/* File: tb/cnb_mem_model.sv */
// Partner model: data memory and IO registers facing the unit.
// Assumes one-cycle read and write strobes on clk_i.
module cnb_mem_model (
   input wire logic clk_i, rst_n_i, m_rd_i, m_wr_i, p_rd_i, p_wr_i,
   input wire logic [7:0] m_addr_i, m_wdata_i, p_wdata_i,
   input wire logic [5:0] p_addr_i,
   output logic [7:0] m_rdata_o, p_rdata_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] mem [256];
   logic [7:0] io [64];
   // ------------
   // Storage
   // ------------
   // Read data stand while the strobe does, since the unit samples them
   // on the edge that ends the strobe; otherwise the inverse shows.
   assign m_rdata_o = m_rd_i ? mem[m_addr_i] : ~mem[m_addr_i];
   assign p_rdata_o = p_rd_i ? io[p_addr_i] : ~io[p_addr_i];
   // Writes land on the strobe; the bench preloads between operations.
   always @(posedge clk_i) begin
      if (m_wr_i) mem[m_addr_i] <= m_wdata_i;
      if (p_wr_i) io[p_addr_i] <= p_wdata_i;
   end
endmodule

/* File: tb/cnb_assertions.sv */
// Checker for the compare, negate and bit unit, bound to its ports.
// Assumes read data stand in the same cycle as the read strobe.
module cnb_checker (
   input wire logic clk_i, rst_n_i, start_i, busy_o, done_o,
   input wire logic mem_rd_o, io_rd_o, mem_wr_o, io_wr_o, flag_wr_o,
   input wire logic [3:0] op_i,
   input wire logic [2:0] bit_sel_i,
   input wire logic [7:0] accumulator_i, flag_i, mem_rdata_i, io_rdata_i,
   input wire logic [7:0] port_dir_i, port_pin_i, mem_wdata_o, io_wdata_o,
   input wire logic [7:0] flag_wdata_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [3:0] op;
   logic [2:0] sel;
   logic [7:0] acc, flg, dir, pin, b, mr, ir;
   logic cmp, is_set, mbit, iobit, swp;
   // ------------
   // Capture
   // ------------
   // Operands are held from the taking edge until the results appear.
   always_ff @(posedge clk_i) begin
      if (start_i && !busy_o) begin
         op <= op_i;
         sel <= bit_sel_i;
         acc <= accumulator_i;
         flg <= flag_i;
         dir <= port_dir_i;
         pin <= port_pin_i;
      end
   end
   // Read data seen one edge earlier, and decoded op kinds.
   always_ff @(posedge clk_i) begin
      mr <= mem_rdata_i;
      ir <= io_rdata_i;
   end
   assign b = 8'h01 << sel;
   assign cmp = op inside {cmp_neg_bit_pkg::OP_COMP_AM,
      cmp_neg_bit_pkg::OP_COMP_MA};
   assign is_set = op inside {cmp_neg_bit_pkg::OP_SET_IO,
      cmp_neg_bit_pkg::OP_SET_M};
   assign mbit = op inside {cmp_neg_bit_pkg::OP_SET_M,
      cmp_neg_bit_pkg::OP_CLR_M};
   assign iobit = op inside {cmp_neg_bit_pkg::OP_SET_IO,
      cmp_neg_bit_pkg::OP_CLR_IO};
   assign swp = op == cmp_neg_bit_pkg::OP_SWAPC_IO;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   a_op_timing:
   assert property (start_i && !busy_o |=> busy_o && (mem_rd_o || io_rd_o)
      ##1 done_o && busy_o ##1 !done_o && !busy_o)
      else $error("op timing wrong");
   a_neg_result:
   assert property (mem_wr_o && op == cmp_neg_bit_pkg::OP_NEG_M |->
      mem_wdata_o == 8'h00 - mr && flag_wr_o &&
      flag_wdata_o == {flg[7:1], mr == 8'h00}) else $error("negate wrong");
   a_cmp_no_write:
   assert property (flag_wr_o && cmp |-> !mem_wr_o && !io_wr_o)
      else $error("compare wrote an operand");
   a_equal_zero:
   assert property (flag_wr_o && cmp && mr == acc |-> flag_wdata_o[0])
      else $error("equal not zero");
   a_borrow_carry:
   assert property (flag_wr_o && cmp |-> flag_wdata_o[1] ==
      (op == cmp_neg_bit_pkg::OP_COMP_AM ? acc < mr : mr < acc))
      else $error("borrow not in carry");
   a_bit_mem:
   assert property (mem_wr_o && mbit |-> mem_wdata_o ==
      (is_set ? mr | b : mr & ~b)) else $error("memory bit wrong");
   a_bit_io:
   assert property (io_wr_o && iobit |-> io_wdata_o ==
      (is_set ? ir | b : ir & ~b)) else $error("io bit wrong");
   a_bit_flags:
   assert property (done_o && (mbit || iobit) |->
      !flag_wr_o || flag_wdata_o == flg) else $error("bit op moved flags");
   a_swap_out:
   assert property (io_wr_o && swp |-> io_wdata_o ==
      (ir & ~b | (flg[1] ? b : 8'h00))) else $error("swap output wrong");
   a_swap_carry:
   assert property (flag_wr_o && swp |-> flag_wdata_o ==
      {flg[7:2], dir[sel] ? |(ir & b) : pin[sel], flg[0]})
      else $error("swap carry wrong");
endmodule
bind cmp_neg_bit_unit cnb_checker chk_u (.*);

/* File: tb/testbench.sv */
// Self-checking bench for the compare, negate and bit unit.
// Assumes the partner model answers reads in the same cycle as the strobe.
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_i = 1'b0, rst_n_i = 1'b0, start_i = 1'b0, fl;
   logic [3:0] op_i = 4'h0;
   logic [7:0] mem_addr_i = 8'h3C, accumulator_i = 8'h00, flag_i = 8'h00;
   logic [7:0] port_dir_i = 8'h00, port_pin_i = 8'h00, fw, bv;
   logic [5:0] io_addr_i = 6'h05, io_addr_o;
   logic [2:0] bit_sel_i = 3'h0;
   logic [7:0] mem_rdata_i, io_rdata_i, mem_addr_o, mem_wdata_o;
   logic [7:0] io_wdata_o, flag_wdata_o;
   logic mem_rd_o, mem_wr_o, io_rd_o, io_wr_o, flag_wr_o, busy_o, done_o;
   int n_fail = 0, comparisons = 0;
   cmp_neg_bit_unit dut_u (.*);
   cnb_mem_model ptn_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .m_addr_i(mem_addr_o), .m_rd_i(mem_rd_o), .m_wr_i(mem_wr_o),
      .m_wdata_i(mem_wdata_o), .p_addr_i(io_addr_o), .p_rd_i(io_rd_o),
      .p_wr_i(io_wr_o), .p_wdata_i(io_wdata_o), .m_rdata_o(mem_rdata_i),
      .p_rdata_o(io_rdata_i));
   initial forever #5 clk_i = ~clk_i;
   // ------------
   // Helpers
   // ------------
   task automatic chk(input string nm, input logic [7:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic end_of_test();
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // One operation: start, wait for done, keep flags, let writes land.
   task automatic run(input logic [3:0] op, input logic [7:0] a,
      input logic [2:0] s, input logic [7:0] f);
      int n;
      @(posedge clk_i);
      start_i <= 1'b1;
      op_i <= op;
      accumulator_i <= a;
      bit_sel_i <= s;
      flag_i <= f;
      @(posedge clk_i);
      start_i <= 1'b0;
      n = 0;
      do begin
         @(posedge clk_i);
         #1;
         n++;
      end while (done_o !== 1'b1 && n < 8);
      chk("done", {7'h00, done_o}, 8'h01);
      fl = flag_wr_o;
      fw = flag_wdata_o;
      @(posedge clk_i);
      #1;
   endtask
   // Flags of x minus y over a flag byte whose upper half is all ones.
   function automatic logic [7:0] exp_cmp(input logic [7:0] x, y);
      logic [7:0] d;
      d = x - y;
      return {4'hF, x[7] != y[7] && d[7] != x[7], x[3:0] < y[3:0], x < y,
         d == 8'h00};
   endfunction
   // ------------
   // Scenarios
   // ------------
   task automatic t_neg();
      logic [7:0] v [3] = '{8'h38, 8'h00, 8'h80};
      foreach (v[i]) begin
         ptn_u.mem[8'h3C] = v[i];
         run(cmp_neg_bit_pkg::OP_NEG_M, 8'h11, 3'h0, 8'hFE);
         chk("neg mem", ptn_u.mem[8'h3C], 8'h00 - v[i]);
         chk("neg flags", fw, {7'h7F, v[i] == 8'h00});
      end
   endtask
   task automatic t_cmp();
      logic [7:0] a [5] = '{8'h38, 8'h38, 8'h42, 8'h80, 8'h7F};
      logic [7:0] m [5] = '{8'h38, 8'h42, 8'h38, 8'h01, 8'hFF};
      foreach (a[i]) for (int k = 0; k < 2; k++) begin
         ptn_u.mem[8'h3C] = m[i];
         run(k ? cmp_neg_bit_pkg::OP_COMP_MA : cmp_neg_bit_pkg::OP_COMP_AM,
            a[i], 3'h0, 8'hF0);
         chk("cmp flags", fw,
            k ? exp_cmp(m[i], a[i]) : exp_cmp(a[i], m[i]));
         chk("cmp mem", ptn_u.mem[8'h3C], m[i]);
      end
   endtask
   task automatic t_bit();
      logic [3:0] ob [4] = '{cmp_neg_bit_pkg::OP_SET_IO,
         cmp_neg_bit_pkg::OP_CLR_IO, cmp_neg_bit_pkg::OP_SET_M,
         cmp_neg_bit_pkg::OP_CLR_M};
      for (int s = 0; s < 8; s++) begin
         ptn_u.io[6'h05] = 8'hA5;
         ptn_u.mem[8'h3C] = 8'h5A;
         bv = 8'h01 << s;
         for (int k = 0; k < 4; k++) begin
            run(ob[k], 8'h00, s[2:0], 8'h0F);
            chk("bit", k < 2 ? ptn_u.io[6'h05] : ptn_u.mem[8'h3C],
               (k < 2 ? 8'hA5 : 8'h5A) & ~bv | (k[0] ? 8'h00 : bv));
            chk("bit flags", fl ? fw : 8'h0F, 8'h0F);
         end
      end
   endtask
   task automatic t_swap();
      for (int k = 0; k < 4; k++) begin
         ptn_u.io[6'h05] = 8'h5A;
         @(posedge clk_i);
         port_dir_i <= k[1] ? 8'h00 : 8'hFF;
         port_pin_i <= k[0] ? 8'h00 : 8'hFF;
         repeat (3) @(posedge clk_i);
         run(cmp_neg_bit_pkg::OP_SWAPC_IO, 8'h00, 3'h3, k[0] ? 8'hF7 : 8'hF5);
         chk("swap io", ptn_u.io[6'h05], k[0] ? 8'h5A : 8'h52);
         chk("swap flags", fw, (k[1] ? !k[0] : 1'b1) ? 8'hF7 : 8'hF5);
      end
   endtask
   // Main sequence and a watchdog well beyond its few hundred cycles.
   initial begin
      repeat (8) @(posedge clk_i);
      rst_n_i <= 1'b1;
      t_neg();
      t_cmp();
      t_bit();
      t_swap();
      end_of_test();
   end
   initial begin
      repeat (3000) @(posedge clk_i);
      n_fail++;
      end_of_test();
   end
endmodule
